/* File: src/srl_pkg.sv */
// shared constants for the serial receiver link control registers
package srl_pkg;
  // ==================== register map
  localparam logic [14:0] ADDR_TUNE_A     = 15'h02ab;
  localparam logic [14:0] ADDR_CAL2       = 15'h02ae;
  localparam logic [14:0] ADDR_TUNE_B     = 15'h02b1;
  localparam logic [14:0] ADDR_TUNE_C     = 15'h02b2;
  localparam logic [14:0] ADDR_GEN0       = 15'h0300;
  localparam logic [14:0] ADDR_GEN1       = 15'h0301;
  localparam logic [14:0] ADDR_PAGED_LO   = 15'h0401;
  localparam logic [14:0] ADDR_PAGED_HI   = 15'h047e;
  localparam logic [14:0] ADDR_CSUM_FIRST = 15'h040e;
  localparam logic [14:0] ADDR_CSUM_LAST  = 15'h0446;
  // ==================== reset values
  localparam logic [7:0] RST_TUNE_A   = 8'h93;
  localparam logic [7:0] RST_TUNE_B   = 8'hc3;
  localparam logic [7:0] RST_TUNE_C   = 8'h93;
  localparam logic       RST_CAL2     = 1'h0;
  localparam logic [7:0] RST_GEN0     = 8'h00;
  localparam logic [2:0] RST_SUBCLASS = 3'h1;
  // ==================== field positions
  localparam int unsigned GEN0_CSUM_BIT = 6;
  localparam int unsigned GEN0_MODE_BIT = 3;
  localparam int unsigned GEN0_PAGE_BIT = 2;
  localparam int unsigned CSUM_IDX_LSB  = 3;
  localparam logic [2:0]  SUBCLASS_ONE  = 3'h1;
  // per packed byte: low field mask, high field mask and its shift; lane id byte left out
  localparam logic [12:0][7:0] FLD_LO_MASK = {8'h00, 8'h00, 8'h1f, 8'h1f, 8'h1f, 8'h1f,
    8'hff, 8'h1f, 8'hff, 8'h1f, 8'h00, 8'h0f, 8'hff};
  localparam logic [12:0][7:0] FLD_HI_MASK = {8'h00, 8'h00, 8'h80, 8'he0, 8'he0, 8'hc0,
    8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  localparam logic [12:0][2:0] FLD_HI_SHIFT = {3'h0, 3'h0, 3'h7, 3'h5, 3'h5, 3'h6,
    3'h0, 3'h0, 3'h0, 3'h7, 3'h0, 3'h0, 3'h0};
  // ==================== serial frame: 16 command bits then 8 data bits
  localparam logic [4:0] SPI_CMD_LAST   = 5'h0f;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
  typedef enum logic [1:0] {SRL_CMD, SRL_DATA, SRL_HOLD} srl_spi_state_t;
endpackage

/* File: src/srl_param_sum.sv */
// local link parameter checksum for one link, one result per lane
module srl_param_sum (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // configuration
  input  wire logic [12:0][7:0] cfg_i,
  input  wire logic [7:0][4:0]  lane_id_i,
  input  wire logic             mode_packed_i,
  // stored checksums
  output logic [7:0][7:0]       sum_o
);
  logic [7:0]      field_base;
  logic [7:0]      packed_base;
  logic [7:0][7:0] sum_d;

  always_comb begin
    field_base  = 8'h00;
    packed_base = 8'h00;
    for (int b = 0; b < 13; b++) begin
      packed_base = 8'(packed_base + cfg_i[b]);
      field_base  = 8'(field_base + (cfg_i[b] & srl_pkg::FLD_LO_MASK[b])
                    + ((cfg_i[b] & srl_pkg::FLD_HI_MASK[b]) >> srl_pkg::FLD_HI_SHIFT[b]));
    end
    for (int l = 0; l < 8; l++) begin
      sum_d[l] = mode_packed_i ? packed_base : 8'(field_base + {3'h0, lane_id_i[l]});
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sum_o <= '0;
    end else begin
      sum_o <= sum_d;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  packed_sum_a: assert property (mode_packed_i |=> sum_o[0] == $past(packed_base))
    else $error("packed checksum not the byte sum");
  field_sum_a: assert property (!mode_packed_i |=>
    sum_o[3] == 8'($past(field_base) + {3'h0, $past(lane_id_i[3])}))
    else $error("field checksum wrong for lane 3");
endmodule

/* File: src/srl_ctrl_regs.sv */
// control register slice of the serial receiver, reached over the serial control port
module srl_ctrl_regs (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // serial control port pins
  input  wire logic             spi_sclk_i,
  input  wire logic             spi_cs_n_i,
  input  wire logic             spi_sdio_i,
  output logic                  spi_sdio_o,
  output logic                  spi_sdio_oe_o,
  // packed link configuration and lane ids
  input  wire logic [12:0][7:0] link0_cfg_i,
  input  wire logic [12:0][7:0] link1_cfg_i,
  input  wire logic [7:0][4:0]  lane_id_i,
  // lane termination
  output logic [7:0]            lane_term_tuning_a_o,
  output logic [7:0]            lane_term_tuning_b_o,
  output logic [7:0]            lane_term_tuning_c_o,
  output logic                  lane_group_two_cal_trigger_o,
  // receiver controls
  output logic                  link_mode_dual_o,
  output logic                  link_page_o,
  output logic [1:0]            link_enable_o,
  output logic [2:0]            local_subclass_select_o,
  output logic                  subclass_one_o
);
  // ==================== pin synchronisers
  logic sclk_m_q, sclk_s_q, sclk_p_q;
  logic cs_m_q, cs_s_q;
  logic sdio_m_q, sdio_s_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_m_q <= 1'h0;
      sclk_s_q <= 1'h0;
      sclk_p_q <= 1'h0;
      cs_m_q   <= 1'h1;
      cs_s_q   <= 1'h1;
      sdio_m_q <= 1'h0;
      sdio_s_q <= 1'h0;
    end else begin
      sclk_m_q <= spi_sclk_i;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      cs_m_q   <= spi_cs_n_i;
      cs_s_q   <= cs_m_q;
      sdio_m_q <= spi_sdio_i;
      sdio_s_q <= sdio_m_q;
    end
  end

  // ==================== serial frame engine
  srl_pkg::srl_spi_state_t st_d, st_q;
  logic [4:0]  cnt_d, cnt_q;
  logic [14:0] sh_d, sh_q;
  logic [14:0] addr_d, addr_q;
  logic        rd_d, rd_q;
  logic [7:0]  out_d, out_q;
  logic [7:0]  wsh_d, wsh_q;
  logic        rise;
  logic        load_rd;
  logic        wr_en;
  logic [15:0] cmd;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;

  assign rise    = sclk_s_q & ~sclk_p_q;
  assign cmd     = {sh_q, sdio_s_q};
  assign wr_data = {wsh_q[6:0], sdio_s_q};

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    addr_d  = addr_q;
    rd_d    = rd_q;
    out_d   = out_q;
    wsh_d   = wsh_q;
    load_rd = 1'h0;
    wr_en   = 1'h0;
    if (cs_s_q) begin
      st_d  = srl_pkg::SRL_CMD;
      cnt_d = 5'h00;
    end else if (rise) begin
      cnt_d = cnt_q + 5'h01;
      unique case (st_q)
        srl_pkg::SRL_CMD: begin
          sh_d = cmd[14:0];
          if (cnt_q == srl_pkg::SPI_CMD_LAST) begin
            st_d    = srl_pkg::SRL_DATA;
            rd_d    = cmd[15];
            addr_d  = cmd[14:0];
            load_rd = cmd[15];
            out_d   = rd_data;
          end
        end
        srl_pkg::SRL_DATA: begin
          out_d = {out_q[6:0], 1'h0};
          wsh_d = wr_data;
          if (cnt_q == srl_pkg::SPI_FRAME_LAST) begin
            st_d  = srl_pkg::SRL_HOLD;
            wr_en = ~rd_q;
          end
        end
        srl_pkg::SRL_HOLD: begin
          cnt_d = cnt_q;
        end
        default: begin
          st_d = srl_pkg::SRL_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q   <= srl_pkg::SRL_CMD;
      cnt_q  <= 5'h00;
      sh_q   <= 15'h0000;
      addr_q <= 15'h0000;
      rd_q   <= 1'h0;
      out_q  <= 8'h00;
      wsh_q  <= 8'h00;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      addr_q <= addr_d;
      rd_q   <= rd_d;
      out_q  <= out_d;
      wsh_q  <= wsh_d;
    end
  end

  assign spi_sdio_o    = out_q[7];
  assign spi_sdio_oe_o = (st_q == srl_pkg::SRL_DATA) & rd_q & ~cs_s_q;

  // ==================== control registers
  logic [7:0] tune_a_d, tune_a_q;
  logic [7:0] tune_b_d, tune_b_q;
  logic [7:0] tune_c_d, tune_c_q;
  logic       cal_d, cal_q;
  logic       trig_d, trig_q;
  logic       csum_mode_d, csum_mode_q;
  logic       mode_d, mode_q;
  logic       page_d, page_q;
  logic [1:0] en_d, en_q;
  logic [2:0] sub_d, sub_q;

  always_comb begin
    tune_a_d    = tune_a_q;
    tune_b_d    = tune_b_q;
    tune_c_d    = tune_c_q;
    cal_d       = cal_q;
    csum_mode_d = csum_mode_q;
    mode_d      = mode_q;
    page_d      = page_q;
    en_d        = en_q;
    sub_d       = sub_q;
    if (wr_en) begin
      unique case (addr_q)
        srl_pkg::ADDR_TUNE_A: tune_a_d = wr_data;
        srl_pkg::ADDR_TUNE_B: tune_b_d = wr_data;
        srl_pkg::ADDR_TUNE_C: tune_c_d = wr_data;
        srl_pkg::ADDR_CAL2:   cal_d = wr_data[0];
        srl_pkg::ADDR_GEN0: begin
          csum_mode_d = wr_data[srl_pkg::GEN0_CSUM_BIT];
          mode_d      = wr_data[srl_pkg::GEN0_MODE_BIT];
          page_d      = wr_data[srl_pkg::GEN0_PAGE_BIT];
          en_d        = wr_data[1:0];
        end
        srl_pkg::ADDR_GEN1:   sub_d = wr_data[2:0];
        default: begin
        end
      endcase
    end
    trig_d = cal_d & ~cal_q;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tune_a_q    <= srl_pkg::RST_TUNE_A;
      tune_b_q    <= srl_pkg::RST_TUNE_B;
      tune_c_q    <= srl_pkg::RST_TUNE_C;
      cal_q       <= srl_pkg::RST_CAL2;
      trig_q      <= 1'h0;
      csum_mode_q <= srl_pkg::RST_GEN0[srl_pkg::GEN0_CSUM_BIT];
      mode_q      <= srl_pkg::RST_GEN0[srl_pkg::GEN0_MODE_BIT];
      page_q      <= srl_pkg::RST_GEN0[srl_pkg::GEN0_PAGE_BIT];
      en_q        <= srl_pkg::RST_GEN0[1:0];
      sub_q       <= srl_pkg::RST_SUBCLASS;
    end else begin
      tune_a_q    <= tune_a_d;
      tune_b_q    <= tune_b_d;
      tune_c_q    <= tune_c_d;
      cal_q       <= cal_d;
      trig_q      <= trig_d;
      csum_mode_q <= csum_mode_d;
      mode_q      <= mode_d;
      page_q      <= page_d;
      en_q        <= en_d;
      sub_q       <= sub_d;
    end
  end

  assign lane_term_tuning_a_o         = tune_a_q;
  assign lane_term_tuning_b_o         = tune_b_q;
  assign lane_term_tuning_c_o         = tune_c_q;
  assign lane_group_two_cal_trigger_o = trig_q;
  assign link_mode_dual_o             = mode_q;
  assign link_page_o                  = page_q;
  assign link_enable_o                = en_q;
  assign local_subclass_select_o      = sub_q;
  assign subclass_one_o               = (sub_q == srl_pkg::SUBCLASS_ONE);

  // ==================== checksums and read mux
  logic [7:0][7:0] sum0, sum1;
  logic [14:0]     rd_addr;
  logic [14:0]     csum_off;
  logic            csum_hit;
  logic [7:0]      csum_sel;

  srl_param_sum u_sum0 (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .cfg_i         (link0_cfg_i),
    .lane_id_i     (lane_id_i),
    .mode_packed_i (csum_mode_q),
    .sum_o         (sum0)
  );

  srl_param_sum u_sum1 (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .cfg_i         (link1_cfg_i),
    .lane_id_i     (lane_id_i),
    .mode_packed_i (csum_mode_q),
    .sum_o         (sum1)
  );

  assign rd_addr  = cmd[14:0];
  assign csum_off = rd_addr - srl_pkg::ADDR_CSUM_FIRST;
  assign csum_hit = (rd_addr >= srl_pkg::ADDR_CSUM_FIRST) && (csum_off[2:0] == 3'h0)
                    && (rd_addr <= srl_pkg::ADDR_CSUM_LAST);
  assign csum_sel = page_q ? sum1[csum_off[srl_pkg::CSUM_IDX_LSB +: 3]]
                           : sum0[csum_off[srl_pkg::CSUM_IDX_LSB +: 3]];

  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      srl_pkg::ADDR_TUNE_A: rd_data = tune_a_q;
      srl_pkg::ADDR_TUNE_B: rd_data = tune_b_q;
      srl_pkg::ADDR_TUNE_C: rd_data = tune_c_q;
      srl_pkg::ADDR_CAL2:   rd_data = {7'h00, cal_q};
      srl_pkg::ADDR_GEN0:   rd_data = {1'h0, csum_mode_q, 2'h0, mode_q, page_q, en_q};
      srl_pkg::ADDR_GEN1:   rd_data = {5'h00, sub_q};
      default: begin
        if (csum_hit) begin
          rd_data = csum_sel;
        end
      end
    endcase
  end

  // ==================== checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence cal_rise_s;
    !cal_q ##1 cal_q;
  endsequence

  sequence gen0_wr_s;
    wr_en && (addr_q == srl_pkg::ADDR_GEN0);
  endsequence

  cal_edge_a: assert property (cal_rise_s |-> trig_q ##1 !trig_q)
    else $error("cal bit rise gave no single trigger pulse");
  cal_level_a: assert property (cal_q && $past(cal_q) |-> !trig_q)
    else $error("steady cal bit started a calibration");
  link_mode_a: assert property (gen0_wr_s |=> link_mode_dual_o == $past(wr_data[3]))
    else $error("link mode did not follow write");
  link_en_a: assert property (gen0_wr_s |=> link_enable_o == $past(wr_data[1:0]))
    else $error("link enables did not follow write");
  en_hold_a: assert property (!wr_en |=> $stable(link_enable_o))
    else $error("link enables changed without a write");
  sub_hold_a: assert property (!(wr_en && addr_q == srl_pkg::ADDR_GEN1)
    |=> $stable(local_subclass_select_o))
    else $error("subclass changed without a write");
  rsvd_zero_a: assert property (load_rd && rd_addr == srl_pkg::ADDR_GEN0
    |=> out_q[7] == 1'h0 && out_q[5:4] == 2'h0)
    else $error("reserved bits read nonzero");
  csum_read_a: assert property (load_rd && csum_hit |=> out_q == $past(csum_sel))
    else $error("checksum readback wrong");
  paged_other_a: assert property (load_rd && !csum_hit && rd_addr >= srl_pkg::ADDR_PAGED_LO
    && rd_addr <= srl_pkg::ADDR_PAGED_HI |=> out_q == 8'h00)
    else $error("paged address outside checksums read nonzero");
endmodule

/* File: sim/srl_host_model.sv */
// host side of the serial control port: write, read and cut-short frames
module srl_host_model (
  // clock
  input  wire logic clk_i,
  // serial control port pins
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_sdio_o,
  input  wire logic sdio_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_sdio_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // ==================== one frame; nbits below 24 raises chip select early
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                      input int nbits, output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rd, addr, wdata};
    rdata = 8'h00;
    tick(1);
    spi_cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      // released during read data: toggle so no stale level passes
      if (i < 16 || !rd) spi_sdio_o = frame[23-i];
      else spi_sdio_o = ~spi_sdio_o;
      tick(5);
      spi_sclk_o = 1'b1;
      if (i >= 16) rdata[23-i] = sdio_i;
      tick(5);
      spi_sclk_o = 1'b0;
    end
    tick(1);
    spi_cs_n_o = 1'b1;
    tick(5);
  endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench for the serial receiver control registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i, arst_n_i, sclk, cs_n, host_sdio, dev_sdio, dev_oe, sdio_wire;
  logic [12:0][7:0] link0_cfg, link1_cfg;
  logic [7:0][4:0]  lane_id;
  logic [7:0]       tune_a, tune_b, tune_c, rd;
  logic             cal_trig, mode_dual, page, sub_one;
  logic [1:0]       link_en;
  logic [2:0]       subclass;
  int               errors, checks, pulses;

  assign sdio_wire = dev_oe ? dev_sdio : host_sdio;

  srl_ctrl_regs srl_ctrl_regs_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_sdio_i(sdio_wire), .spi_sdio_o(dev_sdio), .spi_sdio_oe_o(dev_oe),
    .link0_cfg_i(link0_cfg), .link1_cfg_i(link1_cfg), .lane_id_i(lane_id),
    .lane_term_tuning_a_o(tune_a), .lane_term_tuning_b_o(tune_b),
    .lane_term_tuning_c_o(tune_c), .lane_group_two_cal_trigger_o(cal_trig),
    .link_mode_dual_o(mode_dual), .link_page_o(page), .link_enable_o(link_en),
    .local_subclass_select_o(subclass), .subclass_one_o(sub_one));

  srl_host_model srl_host_model_inst (.clk_i(clk_i), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
    .spi_sdio_o(host_sdio), .sdio_i(sdio_wire));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (cal_trig === 1'b1) pulses++;

  // ==================== compare and report
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int exp);
    checks++;
    if (got != exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    srl_host_model_inst.xfer(1'b0, a, d, 24, rd);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    srl_host_model_inst.xfer(1'b1, a, 8'h00, 24, rd);
    chk_byte(rd, exp);
  endtask

  function automatic logic [7:0] exp_sum(input logic m, input logic [12:0][7:0] c,
                                          input logic [4:0] lid);
    logic [7:0] s;
    s = m ? 8'h00 : {3'h0, lid};
    for (int b = 0; b < 13; b++)
      if (m) s += c[b];
      else s += (c[b] & srl_pkg::FLD_LO_MASK[b])
              + ((c[b] & srl_pkg::FLD_HI_MASK[b]) >> srl_pkg::FLD_HI_SHIFT[b]);
    return s;
  endfunction

  // ==================== scenarios
  task automatic t_reset;
    chk_byte({tune_a ^ 8'h93} | {tune_b ^ 8'hc3} | {tune_c ^ 8'h93}, 8'h00);
    chk_byte({3'h0, sub_one, mode_dual, page, link_en}, 8'h10);
    rd_chk(15'h02ab, 8'h93);
    rd_chk(15'h02b1, 8'hc3);
    rd_chk(15'h02b2, 8'h93);
    rd_chk(15'h02ae, 8'h00);
    rd_chk(15'h0300, 8'h00);
    rd_chk(15'h0301, 8'h01);
  endtask

  task automatic t_tuning;
    wr(15'h02ab, 8'h87);
    wr(15'h02b1, 8'hb7);
    wr(15'h02b2, 8'h87);
    chk_byte(tune_a, 8'h87);
    chk_byte(tune_b, 8'hb7);
    chk_byte(tune_c, 8'h87);
    rd_chk(15'h02b1, 8'hb7);
    rd_chk(15'h0200, 8'h00);
  endtask

  task automatic t_cal;
    int p0;
    p0 = pulses;
    wr(15'h02ae, 8'hff);
    chk_count(pulses, p0 + 1);
    rd_chk(15'h02ae, 8'h01);
    wr(15'h02ae, 8'h01);
    chk_count(pulses, p0 + 1);
    wr(15'h02ae, 8'h00);
    wr(15'h02ae, 8'h01);
    chk_count(pulses, p0 + 2);
  endtask

  task automatic t_gen0;
    logic [1:0] i;
    wr(15'h0200, 8'h00);
    rd_chk(15'h0281, 8'h00);
    for (int n = 0; n < 4; n++) begin
      i = n[1:0];
      wr(15'h0300, {4'hf, i[0], i[1], i});
      chk_byte({4'h0, mode_dual, page, link_en}, {4'h0, i[0], i[1], i});
      rd_chk(15'h0300, {4'h4, i[0], i[1], i});
    end
    srl_host_model_inst.xfer(1'b0, 15'h0300, 8'h00, 20, rd);
    rd_chk(15'h0300, 8'h4f);
  endtask

  task automatic t_sub;
    wr(15'h0301, 8'h00);
    chk_byte({4'h0, sub_one, subclass}, 8'h00);
    wr(15'h0301, 8'hf9);
    chk_byte({4'h0, sub_one, subclass}, 8'h09);
    rd_chk(15'h0301, 8'h01);
  endtask

  task automatic t_csum;
    logic [14:0] a;
    for (int m = 0; m < 2; m++)
      for (int pg = 0; pg < 2; pg++) begin
        wr(15'h0300, {1'b0, m[0], 3'h0, pg[0], 2'h0});
        for (int k = 0; k < 8; k++) begin
          a = 15'h040e + 15'(k * 8);
          rd_chk(a, exp_sum(m[0], pg[0] ? link1_cfg : link0_cfg, lane_id[k]));
        end
      end
    wr(15'h040e, 8'h55);
    rd_chk(15'h040e, exp_sum(1'b1, link1_cfg, lane_id[0]));
    rd_chk(15'h0410, 8'h00);
    rd_chk(15'h02b1, 8'hb7);
  endtask

  initial begin
    arst_n_i = 1'b0;
    errors = 0;
    checks = 0;
    pulses = 0;
    for (int b = 0; b < 13; b++) begin
      link0_cfg[b] = 8'h9d + 8'(b * 23);
      link1_cfg[b] = 8'h3c ^ 8'(b * 43);
    end
    for (int k = 0; k < 8; k++) lane_id[k] = 5'h03 + 5'(k * 5);
    repeat (6) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_tuning();
    t_cal();
    t_gen0();
    t_sub();
    t_csum();
    tally_and_finish();
  end

  initial begin
    #4000000;
    errors++;
    tally_and_finish();
  end
endmodule
